/* File: common/hbus_pkg.sv */
package hbus_pkg;

   // =====================================================
   // bus geometry
   localparam int GROUPS  = 4;
   localparam int GROUP_W = 16;
   localparam int DATA_W  = GROUPS * GROUP_W;

   // =====================================================
   // inversion threshold: invert when transitions exceed half a group
   localparam logic [4:0] INV_LIMIT = 5'h08;

   // =====================================================
   // reset values
   localparam logic [DATA_W-1:0] DATA_RST   = 64'h0000000000000000;
   localparam logic [GROUP_W-1:0] GROUP_RST = 16'h0000;
   localparam logic [GROUPS-1:0] FLAGS_RST  = 4'h0;

endpackage : hbus_pkg

/* File: core/group_capture.sv */
`timescale 1ns/1ns
`default_nettype none

module group_capture (
   // clock and reset
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_rst_n,
   // bus side of one group
   input  wire logic [hbus_pkg::GROUP_W-1:0] i_data,
   input  wire logic                        i_inv,
   input  wire logic                        i_strobe_pos,
   input  wire logic                        i_strobe_neg,
   // recovered group
   output logic      [hbus_pkg::GROUP_W-1:0] o_data,
   output logic                             o_strobe
);

   // =====================================================
   // state
   typedef struct packed {
      logic [hbus_pkg::GROUP_W-1:0] data_s1;
      logic [hbus_pkg::GROUP_W-1:0] data_s2;
      logic                         inv_s1;
      logic                         inv_s2;
      logic [2:0]                   pos_s;
      logic [2:0]                   neg_s;
      logic [hbus_pkg::GROUP_W-1:0] data;
      logic                         strobe;
   } cap_state_t;

   cap_state_t state_reg;
   cap_state_t state_next;

   // =====================================================
   // capture
   always_comb begin
      state_next         = state_reg;
      state_next.data_s1 = i_data;
      state_next.data_s2 = state_reg.data_s1;
      state_next.inv_s1  = i_inv;
      state_next.inv_s2  = state_reg.inv_s1;
      state_next.pos_s   = {state_reg.pos_s[1:0], i_strobe_pos};
      state_next.neg_s   = {state_reg.neg_s[1:0], i_strobe_neg};
      state_next.strobe  = 1'b0;
      // either strobe of the pair latches data and flag together
      if ((state_reg.pos_s[1] && !state_reg.pos_s[2]) ||
          (state_reg.neg_s[1] && !state_reg.neg_s[2])) begin
         state_next.data   = state_reg.inv_s2 ? ~state_reg.data_s2 : state_reg.data_s2;
         state_next.strobe = 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_reg         <= '0;
         state_reg.data    <= hbus_pkg::GROUP_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign o_data   = state_reg.data;
   assign o_strobe = state_reg.strobe;

endmodule : group_capture

`default_nettype wire

/* File: core/hbus_data_phase.sv */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - four group_inversion_flag lines travel with data, marking inverted polarity per group
// - flag asserted exactly when its group is driven inverted, deasserted when true
// - invert a group when true value would toggle more than half its lines
// - flag 3..0 cover data 63:48, 47:32, 31:16, 15:0 respectively
// - driver asserts transfer_valid on every data transfer
// - idle clocks drop transfer_valid; receiver accepts only while it is asserted
// - group_strobe_neg n captures data group n and flag n
// - group_strobe_pos n captures data group n and flag n
// - receiver re-inverts every group whose flag is active
module hbus_data_phase (
   // clock and reset
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_rst_n,
   // host_processor_bus clock, sampled
   input  wire logic                       i_bus_clk,
   // this end owns the data bus
   input  wire logic                       i_drive_en,
   // data lines
   input  wire logic [hbus_pkg::DATA_W-1:0] i_data_in,
   output logic      [hbus_pkg::DATA_W-1:0] o_data_out,
   output logic                            o_data_oe,
   // group_inversion_flag lines
   input  wire logic [hbus_pkg::GROUPS-1:0] i_inv_in,
   output logic      [hbus_pkg::GROUPS-1:0] o_inv_out,
   output logic                            o_inv_oe,
   // transfer_valid line
   input  wire logic                       i_valid_in,
   output logic                            o_valid_out,
   output logic                            o_valid_oe,
   // group_strobe_pos lines
   input  wire logic [hbus_pkg::GROUPS-1:0] i_strobe_pos_in,
   output logic      [hbus_pkg::GROUPS-1:0] o_strobe_pos_out,
   output logic                            o_strobe_pos_oe,
   // group_strobe_neg lines
   input  wire logic [hbus_pkg::GROUPS-1:0] i_strobe_neg_in,
   output logic      [hbus_pkg::GROUPS-1:0] o_strobe_neg_out,
   output logic                            o_strobe_neg_oe,
   // user transmit side
   input  wire logic                       i_tx_valid,
   input  wire logic [hbus_pkg::DATA_W-1:0] i_tx_data,
   output logic                            o_tx_ready,
   // user receive side
   output logic                            o_rx_valid,
   output logic      [hbus_pkg::DATA_W-1:0] o_rx_data
);

   localparam int GW = hbus_pkg::GROUP_W;
   localparam int NG = hbus_pkg::GROUPS;

   // =====================================================
   // state
   typedef struct packed {
      logic [2:0]                  bclk_s;
      logic [1:0]                  vld_s;
      logic [hbus_pkg::DATA_W-1:0] tx_lines;
      logic [NG-1:0]               tx_inv;
      logic                        tx_valid;
      logic                        pos;
      logic                        neg;
      logic [NG-1:0]               pending;
      logic [hbus_pkg::DATA_W-1:0] rx_word;
      logic                        rx_valid;
   } bus_state_t;

   bus_state_t state_reg;
   bus_state_t state_next;

   // =====================================================
   // transition count between two levels of one group
   function automatic logic [4:0] flips(input logic [GW-1:0] a, input logic [GW-1:0] b);
      logic [4:0]    cnt;
      logic [GW-1:0] d;
      cnt = 5'h00;
      d   = a ^ b;
      for (int k = 0; k < GW; k++) begin
         cnt = cnt + {4'h0, d[k]};
      end
      return cnt;
   endfunction : flips

   // =====================================================
   // per-group receive path
   logic [hbus_pkg::DATA_W-1:0] grp_data;
   logic [NG-1:0]               grp_strobe;

   generate
      for (genvar g = 0; g < NG; g++) begin : g_grp
         group_capture u_cap (
            .i_sys_clk    (i_sys_clk),
            .i_rst_n      (i_rst_n),
            .i_data       (i_data_in[g*GW +: GW]),
            .i_inv        (i_inv_in[g]),
            .i_strobe_pos (i_strobe_pos_in[g]),
            .i_strobe_neg (i_strobe_neg_in[g]),
            .o_data       (grp_data[g*GW +: GW]),
            .o_strobe     (grp_strobe[g])
         );
      end
   endgenerate

   // =====================================================
   // next state
   logic bclk_rise;
   logic bclk_fall;
   logic slot;
   logic take;

   assign bclk_rise = state_reg.bclk_s[1] && !state_reg.bclk_s[2];
   assign bclk_fall = !state_reg.bclk_s[1] && state_reg.bclk_s[2];
   // each half of a bus clock is one transfer slot
   assign slot      = bclk_rise || bclk_fall;
   assign take      = slot && i_drive_en && i_tx_valid;

   always_comb begin
      logic [GW-1:0] grp_new;
      logic [GW-1:0] grp_old;
      logic          inv;
      grp_new  = '0;
      grp_old  = '0;
      inv      = 1'b0;
      state_next          = state_reg;
      state_next.bclk_s   = {state_reg.bclk_s[1:0], i_bus_clk};
      state_next.vld_s    = {state_reg.vld_s[0], i_valid_in};
      state_next.rx_valid = 1'b0;

      // ===== transmit
      if (slot) begin
         if (take) begin
            for (int g = 0; g < NG; g++) begin
               grp_new = i_tx_data[g*GW +: GW];
               grp_old = state_reg.tx_lines[g*GW +: GW];
               inv     = flips(grp_new, grp_old) > hbus_pkg::INV_LIMIT;
               state_next.tx_lines[g*GW +: GW] = inv ? ~grp_new : grp_new;
               state_next.tx_inv[g] = inv;
            end
         end
         // idle slot: lines hold their levels, so the reference is kept
         state_next.tx_valid = take;
         state_next.pos      = take && bclk_rise;
         state_next.neg      = take && bclk_fall;
      end
      if (!i_drive_en) begin
         state_next.tx_valid = 1'b0;
         state_next.pos      = 1'b0;
         state_next.neg      = 1'b0;
      end

      // ===== receive, only while the far end drives
      if (!i_drive_en) begin
         if (&state_reg.pending) begin
            state_next.rx_valid = 1'b1;
            state_next.pending  = hbus_pkg::FLAGS_RST;
         end else if (state_reg.vld_s[1]) begin
            for (int g = 0; g < NG; g++) begin
               if (grp_strobe[g]) begin
                  state_next.rx_word[g*GW +: GW] = grp_data[g*GW +: GW];
                  state_next.pending[g]          = 1'b1;
               end
            end
         end
      end else begin
         state_next.pending = hbus_pkg::FLAGS_RST;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_reg          <= '0;
         state_reg.tx_lines <= hbus_pkg::DATA_RST;
         state_reg.tx_inv   <= hbus_pkg::FLAGS_RST;
         state_reg.pending  <= hbus_pkg::FLAGS_RST;
         state_reg.rx_word  <= hbus_pkg::DATA_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // =====================================================
   // outputs
   assign o_data_out       = state_reg.tx_lines;
   assign o_inv_out        = state_reg.tx_inv;
   assign o_valid_out      = state_reg.tx_valid;
   assign o_strobe_pos_out = {NG{state_reg.pos}};
   assign o_strobe_neg_out = {NG{state_reg.neg}};
   assign o_data_oe        = i_drive_en;
   assign o_inv_oe         = i_drive_en;
   assign o_valid_oe       = i_drive_en;
   assign o_strobe_pos_oe  = i_drive_en;
   assign o_strobe_neg_oe  = i_drive_en;
   assign o_tx_ready       = slot && i_drive_en;
   assign o_rx_valid       = state_reg.rx_valid;
   assign o_rx_data        = state_reg.rx_word;

endmodule : hbus_data_phase

`default_nettype wire

/* File: tb/hbus_checker.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// transmit side protocol checks
module hbus_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_rst_n,
   input wire logic        i_bus_clk,
   input wire logic        i_drive_en,
   input wire logic        i_tx_valid,
   input wire logic [63:0] i_tx_data,
   input wire logic        o_tx_ready,
   input wire logic [63:0] o_data_out,
   input wire logic [3:0]  o_inv_out,
   input wire logic        o_valid_out,
   input wire logic [3:0]  o_strobe_pos_out,
   input wire logic [3:0]  o_strobe_neg_out,
   input wire logic        o_rx_valid,
   input wire logic        o_data_oe,
   input wire logic        o_inv_oe,
   input wire logic        o_valid_oe,
   input wire logic        o_strobe_pos_oe,
   input wire logic        o_strobe_neg_oe
);
   logic tk;
   assign tk = o_tx_ready & i_tx_valid;
   // exactly 8 toggles must still go out true
   function automatic logic [3:0] pick(input logic [63:0] n, input logic [63:0] r);
      for (int g = 0; g < 4; g++)
         pick[g] = $countones(n[g*16+:16] ^ r[g*16+:16]) > 8;
   endfunction : pick
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   inv_choice_a: assert property
      (tk |=> o_inv_out == pick($past(i_tx_data), $past(o_data_out)))
      else $error("inversion choice wrong");
   flag_map_a: assert property
      (tk |=> (o_data_out ^ $past(i_tx_data)) == {{16{o_inv_out[3]}}, {16{o_inv_out[2]}},
         {16{o_inv_out[1]}}, {16{o_inv_out[0]}}}) else $error("flag does not match data");
   valid_mark_a: assert property (tk |=> o_valid_out)
      else $error("valid missing on transfer");
   idle_slot_a: assert property
      (o_tx_ready && !i_tx_valid |=> !o_valid_out && !(|{o_strobe_pos_out, o_strobe_neg_out}))
      else $error("idle slot not idle");
   pos_slot_a: assert property
      (tk && i_bus_clk |=> o_strobe_pos_out == 4'hF && o_strobe_neg_out == 4'h0)
      else $error("rising slot strobe wrong");
   neg_slot_a: assert property
      (tk && !i_bus_clk |=> o_strobe_neg_out == 4'hF && o_strobe_pos_out == 4'h0)
      else $error("falling slot strobe wrong");
   ref_hold_a: assert property (i_drive_en && !tk |=> $stable(o_data_out))
      else $error("driven lines moved without transfer");
   rx_quiet_a: assert property (i_drive_en [*3] |=> !o_rx_valid)
      else $error("receive while driving");
   // flag lines must be released and driven together with the data lines
   oe_follow_a: assert property
      ({o_data_oe, o_inv_oe, o_valid_oe, o_strobe_pos_oe, o_strobe_neg_oe} == {5{i_drive_en}})
      else $error("output enables disagree with direction");
endmodule : hbus_checker
`default_nettype wire

/* File: tb/bus_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// far-side data driver
module bus_partner (
   input  wire logic        i_bus_clk,
   output logic      [63:0] o_data,
   output logic      [3:0]  o_inv,
   output logic             o_valid,
   output logic      [3:0]  o_pos,
   output logic      [3:0]  o_neg
);
   initial {o_data, o_inv, o_valid, o_pos, o_neg} = '0;
   // reference is what is on the wire, not the true word
   function automatic logic [67:0] enc(input logic [63:0] w, input logic [63:0] r);
      enc = {4'h0, w};
      for (int g = 0; g < 4; g++) begin
         if ($countones(w[g*16+:16] ^ r[g*16+:16]) > 8) begin
            enc[g*16+:16] = ~w[g*16+:16];
            enc[64+g] = 1'b1;
         end
      end
   endfunction : enc
   // one slot per bus clock half; strobe drops mid-slot so its next rise is clean
   task automatic send(input logic [63:0] w, input logic v);
      @(i_bus_clk);
      if (v)
         {o_inv, o_data} = enc(w, o_data);
      else
         o_data = ~o_data;
      o_valid = v;
      o_pos = {4{i_bus_clk & v}};
      o_neg = {4{~i_bus_clk & v}};
      #30;
      o_pos = 4'h0;
      o_neg = 4'h0;
   endtask : send
endmodule : bus_partner
`default_nettype wire

/* File: tb/test_hbus_data_phase.sv */
`timescale 1ns/1ns
`default_nettype none
module test_hbus_data_phase;
   logic i_sys_clk, i_rst_n, i_bus_clk, i_drive_en, i_tx_valid, o_tx_ready, o_rx_valid, v;
   logic o_valid_out, o_data_oe, o_inv_oe, o_valid_oe, o_strobe_pos_oe, o_strobe_neg_oe, p_valid;
   logic [63:0] i_tx_data, o_data_out, o_rx_data, p_data, ref_lines, w;
   logic [3:0]  o_inv_out, o_strobe_pos_out, o_strobe_neg_out, p_inv, p_pos, p_neg;
   logic [75:0] txq[$];
   logic [63:0] rxq[$];
   logic [67:0] e;
   logic [1:0]  prev;
   int          fail_count = 0, total_checks = 0, seed = 15;
   // ==========
   // design and far side, wires resolved by output enables
   hbus_data_phase u_hbus_data_phase (
      .i_sys_clk, .i_rst_n, .i_bus_clk, .i_drive_en,
      .i_data_in(o_data_oe ? o_data_out : p_data), .o_data_out, .o_data_oe,
      .i_inv_in(o_inv_oe ? o_inv_out : p_inv), .o_inv_out, .o_inv_oe,
      .i_valid_in(o_valid_oe ? o_valid_out : p_valid), .o_valid_out, .o_valid_oe,
      .i_strobe_pos_in(o_strobe_pos_oe ? o_strobe_pos_out : p_pos), .o_strobe_pos_out,
      .o_strobe_pos_oe, .i_strobe_neg_in(o_strobe_neg_oe ? o_strobe_neg_out : p_neg),
      .o_strobe_neg_out, .o_strobe_neg_oe, .i_tx_valid, .i_tx_data, .o_tx_ready,
      .o_rx_valid, .o_rx_data);
   bus_partner u_bus_partner (.i_bus_clk, .o_data(p_data), .o_inv(p_inv), .o_valid(p_valid),
      .o_pos(p_pos), .o_neg(p_neg));
   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end
   initial begin
      i_bus_clk = 1'b0;
      #2;
      forever begin
         #62 i_bus_clk = 1'b1;
         #63 i_bus_clk = 1'b0;
      end
   end
   // ==========
   // result checking
   task automatic chk_tx(input logic [75:0] got, input logic [75:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_tx
   task automatic chk_rx(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_rx
   always @(posedge i_sys_clk) begin
      prev <= {o_strobe_pos_out[0], o_strobe_neg_out[0]};
      if (o_valid_out && {o_strobe_pos_out[0], o_strobe_neg_out[0]} != prev && txq.size() > 0)
         chk_tx({o_strobe_pos_out, o_strobe_neg_out, o_inv_out, o_data_out}, txq.pop_front());
      if (o_rx_valid && rxq.size() > 0)
         chk_rx(o_rx_data, rxq.pop_front());
   end
   task automatic end_sim;
      if (txq.size() + rxq.size() != 0)
         fail_count++;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      fail_count++;
      end_sim;
   end
   // ==========
   // transmit with idle slots, then receive
   initial begin
      {i_rst_n, i_tx_valid, i_tx_data, ref_lines} = '0;
      i_drive_en = 1'b1;
      repeat (8) @(posedge i_sys_clk);
      #1 i_rst_n = 1'b1;
      for (int i = 0; i < 40; i++) begin
         i_tx_valid = !i || ($random(seed) % 4 != 0);
         i_tx_data = i ? {$random(seed), $random(seed)} : 64'h01FF_00FF_FFFF_0000;
         while (!o_tx_ready) begin
            @(posedge i_sys_clk);
            #1;
         end
         if (i_tx_valid) begin
            e = u_bus_partner.enc(i_tx_data, ref_lines);
            ref_lines = e[63:0];
            txq.push_back({{4{i_bus_clk}}, {4{~i_bus_clk}}, e});
         end
         @(posedge i_sys_clk);
         #1;
      end
      i_tx_valid = 1'b0;
      i_drive_en = 1'b0;
      repeat (40) begin
         w = {$random(seed), $random(seed)};
         v = ($random(seed) % 4) != 0;
         if (v)
            rxq.push_back(w);
         u_bus_partner.send(w, v);
      end
      repeat (20) @(posedge i_sys_clk);
      end_sim;
   end
endmodule : test_hbus_data_phase
bind hbus_data_phase hbus_checker u_hbus_checker (.i_sys_clk, .i_rst_n, .i_bus_clk,
   .i_drive_en, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_data_out, .o_inv_out, .o_valid_out,
   .o_strobe_pos_out, .o_strobe_neg_out, .o_rx_valid, .o_data_oe, .o_inv_oe, .o_valid_oe,
   .o_strobe_pos_oe, .o_strobe_neg_oe);
`default_nettype wire
